// ==== design/sd_seq_pkg.sv ====
// Constants shared by the sigma-delta conversion sequencer
package sd_seq_pkg;

   // Phase lengths in master clock cycles
   localparam int unsigned SETTLE_FIRST_CYC  = 44;   // First settling, fixed choice
   localparam int unsigned SETTLE_CHOP_CYC   = 42;   // Settling before chopped sample
   localparam int unsigned SCALE_CYC         = 163;  // Scaling phase
   localparam int unsigned MOD_DIV           = 2;    // Modulator runs at half rate

   // Channel count and widths
   localparam int unsigned NUM_CH            = 8;
   localparam int unsigned CH_W              = 3;
   localparam int unsigned FW_W              = 7;    // Filter word width
   localparam int unsigned RES_W             = 16;   // Result width
   localparam int unsigned CNT_W             = 12;

   // APB register byte offsets
   localparam logic [7:0] OFS_MODE           = 8'h00;
   localparam logic [7:0] OFS_STATUS         = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT       = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK       = 8'h0c;
   localparam logic [7:0] OFS_CH_CFG         = 8'h20;  // Plus 4 x channel
   localparam logic [7:0] OFS_CH_DATA        = 8'h40;  // Plus 4 x channel
   localparam logic [7:0] OFS_CH_STAT        = 8'h60;  // Plus 4 x channel

   // Mode register fields
   localparam int unsigned MODE_OP_LSB       = 0;    // 2-bit operating mode
   localparam int unsigned MODE_CLAMP_BIT    = 2;
   localparam int unsigned MODE_CH_LSB       = 4;    // Start channel

   // Operating mode encodings
   localparam logic [1:0] OP_IDLE            = 2'h0;
   localparam logic [1:0] OP_SINGLE          = 2'h1;
   localparam logic [1:0] OP_CONT            = 2'h2;

   // Channel configuration fields
   localparam int unsigned CFG_FW_LSB        = 0;
   localparam int unsigned CFG_CHOP_BIT      = 8;
   localparam int unsigned CFG_EN_BIT        = 9;
   localparam int unsigned CFG_DIFF_BIT      = 10;
   localparam int unsigned CFG_BIP_BIT       = 11;

   // Channel status fields
   localparam int unsigned CST_OVR_BIT       = 0;
   localparam int unsigned CST_SIGN_BIT      = 1;
   localparam int unsigned CST_MISSING_REFERENCE_FLAG_BIT     = 2;
   localparam int unsigned CST_RDY_BIT       = 3;

   // Interrupt status bits
   localparam int unsigned IRQ_DONE_BIT      = 0;
   localparam int unsigned IRQ_MISSING_REFERENCE_FLAG_BIT     = 1;
   localparam int unsigned IRQ_OVR_BIT       = 2;

   // Reset values
   localparam logic [11:0] CFG_RESET         = 12'h204;  // Enabled, filter word 4
   localparam logic [RES_W-1:0] MID_CODE     = 16'h8000;

endpackage : sd_seq_pkg

// ==== design/result_encoder.sv ====
// Result clamping, wrap-around coding and sign/overrange flags
`timescale 1ns/100ps
module result_encoder
   import sd_seq_pkg::*;
(
   // Raw averaged result, signed, extended beyond full scale
   input  wire logic signed [RES_W+1:0] rawValue,
   // Configuration
   input  wire logic                    bipolar,
   input  wire logic                    clampEn,
   // Encoded outputs
   output logic        [RES_W-1:0]      dataOut,
   output logic                         signFlag,
   output logic                         overrangeFlag
);

   // Offset binary in bipolar mode: zero lands on mid code
   wire logic signed [RES_W+1:0] shifted =
      bipolar ? rawValue + $signed({2'b00, MID_CODE}) : rawValue;
   wire logic aboveFs = (shifted > $signed({2'b00, 16'hffff}));
   wire logic belowZs = (shifted < $signed(18'h00000));

   // Sign from raw value; overrange derived from the digital result only
   assign signFlag      = rawValue[RES_W+1];
   assign overrangeFlag = aboveFs | belowZs | (!bipolar && signFlag && rawValue != 0);
   // Saturate or wrap to 16 bits
   assign dataOut = (clampEn && aboveFs) ? 16'hffff :
                    (clampEn && belowZs) ? 16'h0000 :
                    shifted[RES_W-1:0];

endmodule : result_encoder

// ==== design/sd_conv_sequencer.sv ====
// Sigma-delta conversion sequencer with APB registers
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/100ps
module sd_conv_sequencer
   import sd_seq_pkg::*;
(
   // Clock and reset
   input  wire logic                core_clk,
   input  wire logic                rst_n,
   // APB slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   // Modulator side
   input  wire logic                modBit,       // Bitstream from modulator
   input  wire logic                refLow,       // Reference comparator, pin level
   output logic                     modClk,
   output logic      [CH_W-1:0]     muxSel,
   output logic                     muxDiff,
   output logic                     muxSwap,
   output logic                     sampling,
   // Ready pin and interrupt
   output logic                     rdy_n,
   output logic                     irq
);

   // Sequencer states
   typedef enum logic [5:0] {
      ST_IDLE    = 6'b000001,
      ST_SETTLE1 = 6'b000010,
      ST_SAMP1   = 6'b000100,
      ST_SETTLE2 = 6'b001000,
      ST_SAMP2   = 6'b010000,
      ST_SCALE   = 6'b100000
   } seq_state_e;

   // Register storage
   seq_state_e               stateReg, stateNext;
   logic [3:0]               modeReg;                 // Op mode and clamp
   logic [CH_W-1:0]          chanReg;                 // Channel being converted
   logic [11:0]              cfgReg   [NUM_CH];       // Per-channel setup
   logic [RES_W-1:0]         dataReg  [NUM_CH];       // Per-channel result
   logic [3:0]               cstReg   [NUM_CH];       // Per-channel status
   logic [2:0]               irqStatReg;              // Sticky events
   logic [2:0]               irqMaskReg;
   logic [CNT_W-1:0]         cntReg;                  // Phase countdown
   logic signed [RES_W+1:0]  accReg;                  // Filter accumulator
   logic signed [RES_W+1:0]  firstReg;                // First sample result
   logic                     divReg;                  // Modulator clock divider
   logic                     refS1Reg, refS2Reg;      // Reference sync
   logic                     modS1Reg, modS2Reg;      // Bitstream sync
   logic                     norefSeenReg;            // Low ref in this cycle
   logic                     rdyPinReg;

   // Number of master clocks in a sampling phase from filter word
   function automatic logic [CNT_W-1:0] sampLen(input logic [FW_W-1:0] fw);
      sampLen = CNT_W'({fw, 4'h0}) + CNT_W'(16);
   endfunction : sampLen

   // Next enabled channel after a given one, wrapping around
   function automatic logic [CH_W-1:0] nextEnabled(input logic [CH_W-1:0] cur,
                                                   input logic [NUM_CH-1:0] en);
      logic [CH_W-1:0] idx;
      nextEnabled = cur;
      for (int i = NUM_CH; i >= 1; i--) begin
         idx = CH_W'(cur + CH_W'(i));
         if (en[idx]) begin
            nextEnabled = idx;
         end
      end
   endfunction : nextEnabled

   // APB decode
   wire logic              apbAcc    = psel & penable;
   wire logic              apbWr     = apbAcc & pwrite;
   wire logic              apbRd     = apbAcc & ~pwrite;
   wire logic [CH_W-1:0]   regCh     = paddr[4:2];
   wire logic              hitMode   = (paddr == OFS_MODE);
   wire logic              hitStat   = (paddr == OFS_STATUS);
   wire logic              hitIrqS   = (paddr == OFS_IRQ_STAT);
   wire logic              hitIrqM   = (paddr == OFS_IRQ_MASK);
   wire logic              hitCfg    = (paddr[7:5] == OFS_CH_CFG[7:5]) && (paddr[1:0] == 2'b00);
   wire logic              hitData   = (paddr[7:5] == OFS_CH_DATA[7:5]) && (paddr[1:0] == 2'b00);
   wire logic              hitCst    = (paddr[7:5] == OFS_CH_STAT[7:5]) && (paddr[1:0] == 2'b00);
   wire logic              hitAny    = hitMode | hitStat | hitIrqS | hitIrqM | hitCfg
                                       | hitData | hitCst;
   wire logic              modeWr    = apbWr & hitMode;
   wire logic              dataRd    = apbRd & hitData;

   // Current channel configuration
   wire logic [11:0]       curCfg    = cfgReg[chanReg];
   wire logic              curChop   = curCfg[CFG_CHOP_BIT];
   wire logic [FW_W-1:0]   curFw     = curCfg[CFG_FW_LSB +: FW_W];
   wire logic [1:0]        opMode    = modeReg[MODE_OP_LSB +: 2];
   wire logic [NUM_CH-1:0] enMask;
   wire logic [NUM_CH-1:0] rdyVec;
   for (genvar g = 0; g < NUM_CH; g++) begin : g_vec
      assign enMask[g] = cfgReg[g][CFG_EN_BIT];
      assign rdyVec[g] = cstReg[g][CST_RDY_BIT];
   end

   // Phase control
   wire logic              cntDone   = (cntReg == CNT_W'(1));
   wire logic              modEdge   = divReg;
   wire logic              finish    = (stateReg == ST_SCALE) && cntDone;
   wire logic              startConv = modeWr && (pwdata[1:0] != OP_IDLE);

   // Chopped average: positive offset term first, negative second
   wire logic signed [RES_W+2:0] sumAvg = {firstReg[RES_W+1], firstReg}
                                          + {accReg[RES_W+1], accReg};
   wire logic signed [RES_W+1:0] rawRes = curChop ? sumAvg[RES_W+2:1] : firstReg;

   // Result coding
   logic [RES_W-1:0] encData;
   logic             encSign;
   logic             encOvr;
   result_encoder u_enc (
      .rawValue      (rawRes),
      .bipolar       (curCfg[CFG_BIP_BIT]),
      .clampEn       (modeReg[MODE_CLAMP_BIT]),
      .dataOut       (encData),
      .signFlag      (encSign),
      .overrangeFlag (encOvr)
   );

   // Next-state decode
   always_comb begin
      stateNext = stateReg;
      unique case (stateReg)
         ST_IDLE:    if (startConv) stateNext = ST_SETTLE1;
         ST_SETTLE1: if (cntDone) stateNext = ST_SAMP1;
         ST_SAMP1:   if (cntDone) stateNext = curChop ? ST_SETTLE2 : ST_SCALE;
         ST_SETTLE2: if (cntDone) stateNext = ST_SAMP2;
         ST_SAMP2:   if (cntDone) stateNext = ST_SCALE;
         ST_SCALE:   if (cntDone) stateNext = (opMode == OP_CONT) ? ST_SETTLE1 : ST_IDLE;
      endcase
      if (modeWr && !startConv) begin
         stateNext = ST_IDLE;
      end else if (startConv) begin
         stateNext = ST_SETTLE1;
      end
   end

   // Phase length loaded on each entry
   wire logic              enterPhase = (stateNext != stateReg) || startConv;
   wire logic [CNT_W-1:0]  phaseLen =
      (stateNext == ST_SETTLE1) ? CNT_W'(SETTLE_FIRST_CYC) :
      (stateNext == ST_SETTLE2) ? CNT_W'(SETTLE_CHOP_CYC) :
      (stateNext == ST_SCALE)   ? CNT_W'(SCALE_CYC) :
                                  sampLen(curFw);

   // State, counter and channel pointer
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stateReg <= ST_IDLE;
         cntReg   <= '0;
         chanReg  <= '0;
      end else begin
         stateReg <= stateNext;
         cntReg   <= enterPhase ? phaseLen : (cntReg - CNT_W'(1));
         if (startConv) begin
            chanReg <= pwdata[MODE_CH_LSB +: CH_W];
         end else if (finish && opMode == OP_CONT) begin
            chanReg <= nextEnabled(chanReg, enMask);
         end
      end
   end

   // Modulator clock divider and synchronisers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         divReg   <= 1'b0;
         refS1Reg <= 1'b0;
         refS2Reg <= 1'b0;
         modS1Reg <= 1'b0;
         modS2Reg <= 1'b0;
      end else begin
         divReg   <= ~divReg;
         refS1Reg <= refLow;
         refS2Reg <= refS1Reg;
         modS1Reg <= modBit;
         modS2Reg <= modS1Reg;
      end
   end

   // Filter: count bitstream ones minus zeros (zeros minus ones in the second sample) on each modulator edge
   wire logic inSample = (stateReg == ST_SAMP1) || (stateReg == ST_SAMP2);
   wire logic signed [RES_W+1:0] step = (modS2Reg ^ (stateReg == ST_SAMP2))
                                        ? 18'sd1 : -18'sd1;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         accReg   <= '0;
         firstReg <= '0;
      end else begin
         if (stateReg == ST_SETTLE1 || stateReg == ST_SETTLE2) begin
            accReg <= '0;
         end else if (inSample && modEdge) begin
            accReg <= accReg + step;
         end
         if (stateReg == ST_SAMP1 && cntDone) begin
            firstReg <= accReg;
         end
      end
   end

   // Missing reference tracking across the conversion
   wire logic converting = (stateReg != ST_IDLE);
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         norefSeenReg <= 1'b0;
      end else if (startConv || finish) begin
         norefSeenReg <= 1'b0;
      end else if (converting && refS2Reg) begin
         norefSeenReg <= 1'b1;
      end
   end

   // Mode register; single conversion falls back to idle when done
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         modeReg <= '0;
      end else if (modeWr) begin
         modeReg <= pwdata[3:0];
      end else if (finish && opMode == OP_SINGLE) begin
         modeReg[MODE_OP_LSB +: 2] <= OP_IDLE;
      end
   end

   // Per-channel config, data and status
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_CH; i++) begin
            cfgReg[i]  <= CFG_RESET;
            dataReg[i] <= '0;
            cstReg[i]  <= '0;
         end
      end else begin
         if (apbWr && hitCfg) begin
            cfgReg[regCh] <= pwdata[11:0];
         end
         if (dataRd) begin
            cstReg[regCh][CST_RDY_BIT] <= 1'b0;
         end
         // Update set wins over a simultaneous read clear
         if (finish) begin
            dataReg[chanReg] <= encData;
            cstReg[chanReg]  <= {1'b1, norefSeenReg | refS2Reg, encSign, encOvr};
         end
      end
   end

   // Ready pin: high at scaling start or mode write, low at finish
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdyPinReg <= 1'b1;
      end else if (finish) begin
         rdyPinReg <= 1'b0;
      end else if (modeWr || (stateNext == ST_SCALE && stateReg != ST_SCALE)) begin
         rdyPinReg <= 1'b1;
      end else if (dataRd && (rdyVec & ~(NUM_CH'(1) << regCh)) == '0) begin
         rdyPinReg <= 1'b1;
      end
   end

   // Interrupt status and mask; set wins over write-one clear
   wire logic [2:0] irqEvents = {finish & encOvr, finish & (norefSeenReg | refS2Reg), finish};
   wire logic [2:0] irqClr    = (apbWr && hitIrqS) ? pwdata[2:0] : 3'h0;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irqStatReg <= '0;
         irqMaskReg <= '0;
         irq        <= 1'b0;
      end else begin
         irqStatReg <= (irqStatReg & ~irqClr) | irqEvents;
         if (apbWr && hitIrqM) begin
            irqMaskReg <= pwdata[2:0];
         end
         irq <= |(((irqStatReg & ~irqClr) | irqEvents) & irqMaskReg);
      end
   end

   // Read mux
   wire logic [31:0] rdMux =
      hitMode ? {28'h0, modeReg} :
      hitStat ? {8'h0, 8'(stateReg), 5'h0, chanReg, rdyVec} :
      hitIrqS ? {29'h0, irqStatReg} :
      hitIrqM ? {29'h0, irqMaskReg} :
      hitCfg  ? {20'h0, cfgReg[regCh]} :
      hitData ? {16'h0, dataReg[regCh]} :
      hitCst  ? {25'h0, chanReg, cstReg[regCh]} : 32'h0;

   // APB answer in the first access cycle, registered outputs
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~hitAny;
         prdata  <= (psel & ~penable & ~pwrite) ? rdMux : 32'h0;
      end
   end

   // Mux and modulator outputs
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         modClk   <= 1'b0;
         muxSel   <= '0;
         muxDiff  <= 1'b0;
         muxSwap  <= 1'b0;
         sampling <= 1'b0;
         rdy_n    <= 1'b1;
      end else begin
         modClk   <= divReg;
         muxSel   <= chanReg;
         muxDiff  <= curCfg[CFG_DIFF_BIT];
         muxSwap  <= (stateReg == ST_SETTLE2) || (stateReg == ST_SAMP2);
         sampling <= inSample;
         rdy_n    <= rdyPinReg;
      end
   end

   // Checks
   chk_settle_first: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(stateReg == ST_SETTLE1) |-> (stateReg == ST_SETTLE1) [*8])
      else $error("settle too short");
   chk_chop_path: assert property (@(posedge core_clk) disable iff (!rst_n)
      (stateReg == ST_SAMP1 && cntDone && curChop && !modeWr) |=> stateReg == ST_SETTLE2)
      else $error("chop path skipped");
   chk_nochop_path: assert property (@(posedge core_clk) disable iff (!rst_n)
      (stateReg == ST_SAMP1 && cntDone && !curChop && !modeWr) |=> stateReg == ST_SCALE)
      else $error("unchopped path wrong");
   chk_scale_len: assert property (@(posedge core_clk) disable iff (!rst_n)
      (stateReg != ST_SCALE ##1 stateReg == ST_SCALE && !modeWr) |-> cntReg == CNT_W'(SCALE_CYC))
      else $error("scale length wrong");
   chk_rdy_low: assert property (@(posedge core_clk) disable iff (!rst_n)
      finish |-> ##2 !rdy_n)
      else $error("ready pin not low");
   chk_rdy_high: assert property (@(posedge core_clk) disable iff (!rst_n)
      (stateReg == ST_SCALE && !finish && !$past(finish)) |-> ##1 rdy_n)
      else $error("ready pin low in scaling");
   chk_single_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
      (finish && opMode == OP_SINGLE && !modeWr) |=> opMode == OP_IDLE && stateReg == ST_IDLE)
      else $error("single not idle");
   chk_ready_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
      finish |=> rdyVec[$past(chanReg)])
      else $error("ready bit not set");
   chk_mod_half: assert property (@(posedge core_clk) disable iff (!rst_n)
      modClk |=> !modClk)
      else $error("modulator clock not half");

endmodule : sd_conv_sequencer

// ==== verif/adc_front_model.sv ====
// Behavioural model of the multiplexed inputs and modulator
`timescale 1ns/100ps
module adc_front_model (
   // Clock from the sequencer
   input  wire logic modClk,
   // Multiplexer controls
   input  wire logic muxSwap,
   input  wire logic sampling,
   // Scenario controls
   input  wire logic posIn,    // Full-scale positive when high
   input  wire logic refDrop,  // Reference collapses when high
   // Modulator outputs
   output logic      modBit,
   output logic      refLow
);
   // Bitstream only advances on the half-rate modulator clock
   always_ff @(posedge modClk) begin
      // Reversed inputs flip the stream; idle output toggles so stale bits never count
      // Idle toggle yields a known level on the first edge even while modBit is still unknown
      modBit <= sampling ? (posIn ^ muxSwap) : (modBit !== 1'b1);
   end
   // Comparator follows the scenario directly
   assign refLow = refDrop;
endmodule : adc_front_model

// ==== verif/sigma_delta_conversion_sequencer_tb.sv ====
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
module sigma_delta_conversion_sequencer_tb;
   import sd_seq_pkg::*;
   logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, errv;
   logic        modBit, refLow, modClk, muxDiff, muxSwap, sampling, rdy_n, irq;
   logic        posIn, refDrop, lastClk;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [2:0]  muxSel;
   int          failures, total_checks, cycles, t0, t1, t2, n;
   int          swapCnt, sampCnt, s0, s1;
   // Device under test
   sd_conv_sequencer DUT (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .modBit(modBit), .refLow(refLow), .modClk(modClk),
      .muxSel(muxSel), .muxDiff(muxDiff), .muxSwap(muxSwap), .sampling(sampling),
      .rdy_n(rdy_n), .irq(irq));
   // Far-side model
   adc_front_model FRONT (.modClk(modClk), .muxSwap(muxSwap),
      .sampling(sampling), .posIn(posIn), .refDrop(refDrop), .modBit(modBit), .refLow(refLow));
   // 100 MHz master clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // Hang guard and swap watcher
   always @(posedge core_clk) begin
      cycles++;
      if (muxSwap === 1'b1) swapCnt++;
      if (sampling === 1'b1) sampCnt++;
      if (cycles == 30000) begin
         failures++;
         tally_and_finish();
      end
   end
   // One APB transfer; request held until pready is sampled
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge core_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Single conversion; cycles from mode write to ready pin low
   task automatic conv(input logic [31:0] cfg, input logic [2:0] ch, input logic clamp,
                       output int t);
      apb(1'b1, 8'(OFS_CH_CFG + 4 * ch), cfg);
      apb(1'b1, OFS_MODE, 32'(OP_SINGLE) | (32'(ch) << MODE_CH_LSB)
                          | (32'(clamp) << MODE_CLAMP_BIT));
      t = 0;
      while (rdy_n !== 1'b1) begin @(posedge core_clk); t++; end
      while (rdy_n !== 1'b0) begin @(posedge core_clk); t++; end
   endtask : conv
   // Verdict
   task automatic tally_and_finish();
      if (failures == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   // Main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, posIn, refDrop} = '0;
      posIn = 1'b1;
      rst_n = 1'b0;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      apb(1'b0, OFS_CH_CFG, '0);
      chk("cfg reset", 32'(CFG_RESET), rdv);
      apb(1'b0, 8'hfc, '0);
      chk("unmapped err", 1, errv);
      chk("unmapped data", 0, rdv);
      // Mask bits enable their interrupt source
      apb(1'b1, OFS_IRQ_MASK, 32'h7);
      // Unchopped: settle, one sample of filter word 4, scale, two-cycle pin delay
      conv(32'h0a04, 3'h0, 1'b0, t0);
      chk("cycle length", 32'(SETTLE_FIRST_CYC + 80 + SCALE_CYC + 2), 32'(t0));
      chk("ready pin", 0, rdy_n);
      apb(1'b0, OFS_STATUS, '0);
      chk("status ready", 1, rdv[0]);
      apb(1'b0, OFS_MODE, '0);
      chk("mode op", OP_IDLE, rdv[1:0]);
      apb(1'b0, OFS_CH_STAT, '0);
      chk("ch ready", 1, rdv[CST_RDY_BIT]);
      chk("sign pos", 0, rdv[CST_SIGN_BIT]);
      chk("irq done", 1, irq);
      apb(1'b0, OFS_CH_DATA, '0);
      chk("data pos", 1, rdv[15]);
      apb(1'b0, OFS_CH_STAT, '0);
      chk("ready cleared", 0, rdv[CST_RDY_BIT]);
      apb(1'b1, OFS_IRQ_MASK, '0);
      repeat (2) @(posedge core_clk);
      chk("irq masked", 0, irq);
      apb(1'b1, OFS_IRQ_MASK, 32'h7);
      apb(1'b1, OFS_IRQ_STAT, 32'h7);
      repeat (2) @(posedge core_clk);
      chk("irq cleared", 0, irq);
      // Chopped: extra settle and a reversed second sample
      s0 = swapCnt;
      s1 = sampCnt;
      conv(32'h0b04, 3'h0, 1'b0, t1);
      chk("chop length", 32'(SETTLE_CHOP_CYC + 80), 32'(t1 - t0));
      chk("swap cycles", 32'(SETTLE_CHOP_CYC + 80), 32'(swapCnt - s0));
      chk("sample cycles", 160, 32'(sampCnt - s1));
      posIn <= 1'b0;
      refDrop <= 1'b1;
      conv(32'h0e05, 3'h1, 1'b0, t2);
      chk("filter word length", 16, 32'(t2 - t0));
      apb(1'b0, 8'(OFS_CH_STAT + 4), '0);
      chk("sign neg", 1, rdv[CST_SIGN_BIT]);
      chk("missing_reference_flag", 1, rdv[CST_MISSING_REFERENCE_FLAG_BIT]);
      refDrop <= 1'b0;
      // Unipolar channel with negative input falls below zero scale
      conv(32'h0205, 3'h2, 1'b1, n);
      apb(1'b0, 8'(OFS_CH_DATA + 8), '0);
      chk("clamp low", 0, rdv);
      apb(1'b0, 8'(OFS_CH_STAT + 8), '0);
      chk("ovr set", 1, rdv[CST_OVR_BIT]);
      conv(32'h0205, 3'h2, 1'b0, n);
      apb(1'b0, 8'(OFS_CH_DATA + 8), '0);
      chk("wrap high", 1, rdv[15]);
      lastClk = modClk;
      @(posedge core_clk);
      chk("mod half rate", !lastClk, modClk);
      // Continuous scan from channel 0 (chopped) to channel 1
      apb(1'b1, OFS_MODE, 32'(OP_CONT));
      while (muxSel !== 3'h0) @(posedge core_clk);
      chk("diff off", 0, muxDiff);
      n = 0;
      while (muxSel !== 3'h1) begin
         @(posedge core_clk);
         n++;
      end
      chk("scan step", 32'(SETTLE_FIRST_CYC + SETTLE_CHOP_CYC + 160 + SCALE_CYC), n);
      chk("next channel", 1, muxSel);
      chk("diff config", 1, muxDiff);
      // Let the new settling phase finish before aborting
      repeat (60) @(posedge core_clk);
      apb(1'b1, OFS_MODE, 32'(OP_IDLE));
      tally_and_finish();
   end
endmodule : sigma_delta_conversion_sequencer_tb
